// ---- core/tws_pkg.sv ----
// Purpose: shared constants and types of the three-wire serial port
// Assumes: 8-bit CPU data bus, 16-bit CPU addresses
// Notes: offsets are CPU byte addresses
package tws_pkg;

  // ************************************************************
  // register addresses
  // ************************************************************
  localparam logic [15:0] ADDR_MODE = 16'hffb0;
  localparam logic [15:0] ADDR_CLKSEL = 16'hffb1;
  localparam logic [15:0] ADDR_TXBUF = 16'hffb2;
  localparam logic [15:0] ADDR_SHIFT = 16'hffb3;

  // ************************************************************
  // mode register fields
  // ************************************************************
  localparam int MODE_EN_BIT = 7;
  localparam int MODE_DIR_BIT = 6;
  localparam int MODE_LSB_BIT = 4;
  localparam int MODE_BUSY_BIT = 0;
  localparam logic [7:0] MODE_RST = 8'h00;

  // ************************************************************
  // clock select register fields
  // ************************************************************
  localparam int CLK_CKP_BIT = 4;
  localparam int CLK_DAP_BIT = 3;
  localparam int CLK_SRC_LSB = 0;
  localparam logic [7:0] CLKSEL_RST = 8'h10;
  localparam logic [2:0] SRC_EXTERNAL = 3'h7;

  // ************************************************************
  // transfer sizing
  // ************************************************************
  localparam logic [3:0] BITS_PER_XFER = 4'h8;
  localparam logic [4:0] EDGES_PER_XFER = 5'h10;
  localparam logic [2:0] PHASE_TYPE_RST = 3'h3;

  // per-frame settings the link side needs
  typedef struct packed {
    logic lsb_first;
    logic dap;
  } tws_cfg_t;

  typedef enum logic [0:0] {
    ST_IDLE,
    ST_RUN
  } tws_state_t;

endpackage

// ---- core/tws_shift_engine.sv ----
// Purpose: link-side shifter, clocked by the normalised serial clock
// Assumes: i_lclk is high (dap=0) or low (dap=1) when idle; sample on
//          its rising edge, launch on its falling edge
// Notes: frame id, tx data and cfg are static while a frame runs
`timescale 1ns/100ps
module tws_shift_engine (
  // clock and reset
  input wire logic i_lclk,
  input wire logic i_rst,
  // frame setup from the system side
  input wire tws_pkg::tws_cfg_t i_cfg,
  input wire logic [7:0] i_tx_data,
  input wire logic [3:0] i_frame_id,
  // serial pins
  input wire logic i_si,
  output logic o_so_bit,
  // results
  output logic o_done_tgl,
  output logic [7:0] o_rx_data
);

  logic [3:0] seen_p_r;
  logic [3:0] seen_n_r;
  logic [3:0] cnt_r;
  logic [7:0] shreg_r;
  logic out_r;
  logic done_r;
  wire new_p = (i_frame_id != seen_p_r);
  wire new_n = (i_frame_id != seen_n_r);
  wire first_bit = i_cfg.lsb_first ? i_tx_data[0] : i_tx_data[7];
  wire next_bit = i_cfg.lsb_first ? shreg_r[0] : shreg_r[7];
  wire mid_frame = (cnt_r != 4'h0) && (cnt_r < tws_pkg::BITS_PER_XFER);

  function automatic logic [7:0] shift_in(input logic [7:0] d,
                                          input logic lsb,
                                          input logic b);
    shift_in = lsb ? {b, d[7:1]} : {d[6:0], b};
  endfunction

  // ************************************************************
  // sample edge: capture input, count bits
  // ************************************************************
  always_ff @(posedge i_lclk or posedge i_rst) begin
    if (i_rst) begin
      seen_p_r <= 4'h0;
      cnt_r <= 4'h0;
      shreg_r <= 8'h00;
      done_r <= 1'b0;
    end else if (new_p) begin
      shreg_r <= shift_in(i_tx_data, i_cfg.lsb_first, i_si);
      cnt_r <= 4'h1;
      seen_p_r <= i_frame_id;
    end else if (cnt_r < tws_pkg::BITS_PER_XFER) begin
      shreg_r <= shift_in(shreg_r, i_cfg.lsb_first, i_si);
      cnt_r <= cnt_r + 4'h1;
      if (cnt_r == tws_pkg::BITS_PER_XFER - 4'h1) begin
        done_r <= ~done_r;
      end
    end
  end

  // ************************************************************
  // launch edge: drive the output latch
  // ************************************************************
  always_ff @(negedge i_lclk or posedge i_rst) begin
    if (i_rst) begin
      seen_n_r <= 4'h0;
      out_r <= 1'b0;
    end else if (new_n) begin
      out_r <= i_cfg.dap ? next_bit : first_bit;
      seen_n_r <= i_frame_id;
    end else if (mid_frame) begin
      out_r <= next_bit;
    end
  end

  // dap=1 shows the first bit before any edge, straight from the buffer
  assign o_so_bit = (i_cfg.dap && new_n) ? first_bit : out_r;
  assign o_done_tgl = done_r;
  assign o_rx_data = shreg_r;

  property p_eight_bits;
    @(posedge i_lclk) disable iff (i_rst)
      $changed(done_r) |-> cnt_r == 4'h8 && $past(cnt_r) == 4'h7;
  endproperty
  a_eight_bits: assert property (p_eight_bits)
    else $error("completion not on the eighth bit");

  property p_last_hold;
    @(posedge i_lclk) disable iff (i_rst)
      cnt_r == 4'h8 && $past(cnt_r) == 4'h8 && !new_p && !new_n
      |-> $stable(out_r);
  endproperty
  a_last_hold: assert property (p_last_hold)
    else $error("output latch moved after the last bit");

endmodule

// ---- core/tws_port.sv ----
// Purpose: three-wire synchronous serial port, CPU side and pins
// Assumes: software keeps clock select and mode stable while busy
// Notes: serial clock is a divided i_sys_clk or the external pin clock
// What this block does
// - clock select resets to 10H
// - phase type three after reset
// - polarity and phase bits pick four types
// - source field picks divider or external clock
// - enable bit gates serial pins and operation
// - direction bit: receive-only or transmit-receive
// - data output low in receive-only mode
// - bit order: MSB or LSB first
// - mode bit zero is read-only busy
// - clearing enable clears busy at once
// - eight bits per transfer, one per clock
// - buffer write starts transmit-receive transfer
// - shift register read starts receive-only transfer
// - busy set once transfer starts
// - eighth bit sets done flag, clears busy
// - mode register resets to 00H
// - clock pin driven only for internal source
// - buffer data shifts out the data pin
// - phase zero: first bit on first edge
// - phase one: first bit at start
// - data pin holds last bit after transfer
`timescale 1ns/100ps
module tws_port (
  // system
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // cpu register access
  input wire logic [15:0] i_cpu_addr,
  input wire logic i_cpu_wr,
  input wire logic i_cpu_rd,
  input wire logic [7:0] i_cpu_wdata,
  output logic [7:0] o_cpu_rdata,
  // serial clock pin
  input wire logic i_ext_sck,
  output logic o_sck,
  output logic o_sck_oe_n,
  // serial data pins
  input wire logic i_si,
  output logic o_so,
  output logic o_so_oe_n,
  // status
  output logic o_busy,
  output logic o_xfer_done
);

  // ************************************************************
  // registers and shared wires
  // ************************************************************
  logic en_r;
  logic dir_r;
  logic lsb_r;
  logic [7:0] clksel_r;
  logic [7:0] tx_r;
  logic [7:0] rx_r;
  logic [3:0] frame_id_r;
  tws_pkg::tws_state_t state_r;
  tws_pkg::tws_state_t state_nxt;
  logic [7:0] rdata_r;
  logic done_pulse_r;
  logic int_sck_r;
  logic [7:0] div_cnt_r;
  logic [4:0] edge_cnt_r;
  logic sck_oe_n_r;
  logic so_oe_n_r;
  logic [2:0] done_sync_r;
  logic done_seen_r;
  logic so_bit;
  logic done_tgl;
  logic [7:0] link_rx;

  function automatic logic hit(input logic [15:0] a,
                               input logic [15:0] base);
    hit = (a == base);
  endfunction

  function automatic logic [7:0] half_m1(input logic [2:0] src);
    half_m1 = 8'((9'h002 << src) - 9'h001);
  endfunction

  // gray count: one bit moves per frame, so the link side never
  // catches a half-changed frame id
  function automatic logic [3:0] gray_next(input logic [3:0] g);
    logic [3:0] b;
    b = {g[3], ^g[3:2], ^g[3:1], ^g[3:0]} + 4'h1;
    gray_next = b ^ {1'b0, b[3:1]};
  endfunction

  // ************************************************************
  // decode
  // ************************************************************
  wire busy = (state_r == tws_pkg::ST_RUN);
  wire ckp = clksel_r[tws_pkg::CLK_CKP_BIT];
  wire dap = clksel_r[tws_pkg::CLK_DAP_BIT];
  wire [2:0] src = clksel_r[tws_pkg::CLK_SRC_LSB +: 3];
  wire ext_src = (src == tws_pkg::SRC_EXTERNAL);
  wire [2:0] phase_type = {1'b0, ckp, dap} + 3'h1;
  wire wr_mode = i_cpu_wr && hit(i_cpu_addr, tws_pkg::ADDR_MODE);
  wire wr_clk = i_cpu_wr && hit(i_cpu_addr, tws_pkg::ADDR_CLKSEL);
  wire wr_tx = i_cpu_wr && hit(i_cpu_addr, tws_pkg::ADDR_TXBUF);
  wire rd_shift = i_cpu_rd && hit(i_cpu_addr, tws_pkg::ADDR_SHIFT);
  wire en_nxt = wr_mode ? i_cpu_wdata[tws_pkg::MODE_EN_BIT] : en_r;
  wire start_tx = wr_tx && dir_r;
  wire start_rx = rd_shift && !dir_r;
  wire start = en_r && !busy && (start_tx || start_rx);
  wire done_evt = (done_sync_r[1] == done_sync_r[2]) &&
                  (done_sync_r[2] != done_seen_r);
  wire [7:0] mode_rd = {en_r, dir_r, 1'b0, lsb_r, 3'b000, busy};
  wire [7:0] cpu_rd_val =
    hit(i_cpu_addr, tws_pkg::ADDR_MODE) ? mode_rd :
    hit(i_cpu_addr, tws_pkg::ADDR_CLKSEL) ? clksel_r :
    hit(i_cpu_addr, tws_pkg::ADDR_TXBUF) ? tx_r :
    hit(i_cpu_addr, tws_pkg::ADDR_SHIFT) ? rx_r : 8'h00;
  wire gen_run = busy && !ext_src && (edge_cnt_r < tws_pkg::EDGES_PER_XFER);
  wire gen_tick = gen_run && (div_cnt_r == half_m1(src));
  // normalised so the engine samples on rise whatever the phase type
  wire lclk_src = ext_src ? i_ext_sck : int_sck_r;
  wire lclk = en_r ? (lclk_src ^ ckp ^ dap) : ~dap;
  wire tws_pkg::tws_cfg_t cfg = '{lsb_first: lsb_r, dap: dap};

  // ************************************************************
  // transfer state
  // ************************************************************
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      tws_pkg::ST_IDLE: begin
        if (start) begin
          state_nxt = tws_pkg::ST_RUN;
        end
      end
      tws_pkg::ST_RUN: begin
        if (done_evt) begin
          state_nxt = tws_pkg::ST_IDLE;
        end
      end
      default: begin
        state_nxt = tws_pkg::ST_IDLE;
      end
    endcase
    if (!en_nxt) begin
      state_nxt = tws_pkg::ST_IDLE;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      state_r <= tws_pkg::ST_IDLE;
      frame_id_r <= 4'h0;
      done_pulse_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      done_pulse_r <= busy && done_evt && en_nxt;
      if (start) begin
        frame_id_r <= gray_next(frame_id_r);
      end
    end
  end

  // ************************************************************
  // cpu registers
  // ************************************************************
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      en_r <= tws_pkg::MODE_RST[tws_pkg::MODE_EN_BIT];
      dir_r <= tws_pkg::MODE_RST[tws_pkg::MODE_DIR_BIT];
      lsb_r <= tws_pkg::MODE_RST[tws_pkg::MODE_LSB_BIT];
      clksel_r <= tws_pkg::CLKSEL_RST;
      tx_r <= 8'h00;
      rdata_r <= 8'h00;
    end else begin
      en_r <= en_nxt;
      if (wr_mode) begin
        dir_r <= i_cpu_wdata[tws_pkg::MODE_DIR_BIT];
        lsb_r <= i_cpu_wdata[tws_pkg::MODE_LSB_BIT];
      end
      if (wr_clk) begin
        clksel_r <= {3'b000, i_cpu_wdata[4:0]};
      end
      if (wr_tx && !busy) begin
        tx_r <= i_cpu_wdata;
      end
      if (i_cpu_rd) begin
        rdata_r <= cpu_rd_val;
      end
    end
  end

  // ************************************************************
  // completion crossing from the link clock
  // ************************************************************
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      done_sync_r <= 3'b000;
      done_seen_r <= 1'b0;
      rx_r <= 8'h00;
    end else begin
      done_sync_r <= {done_sync_r[1:0], done_tgl};
      if (done_evt) begin
        done_seen_r <= done_sync_r[2];
      end
      // shifter is still once the toggle has settled here
      if (done_evt && busy) begin
        rx_r <= link_rx;
      end
    end
  end

  // ************************************************************
  // internal serial clock generator
  // ************************************************************
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      int_sck_r <= ~tws_pkg::CLKSEL_RST[tws_pkg::CLK_CKP_BIT];
      div_cnt_r <= 8'h00;
      edge_cnt_r <= 5'h00;
    end else if (!busy) begin
      int_sck_r <= ~ckp;
      div_cnt_r <= 8'h00;
      edge_cnt_r <= 5'h00;
    end else if (gen_tick) begin
      int_sck_r <= ~int_sck_r;
      div_cnt_r <= 8'h00;
      edge_cnt_r <= edge_cnt_r + 5'h01;
    end else if (gen_run) begin
      div_cnt_r <= div_cnt_r + 8'h01;
    end
  end

  // ************************************************************
  // pin enables
  // ************************************************************
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      sck_oe_n_r <= 1'b1;
      so_oe_n_r <= 1'b1;
    end else begin
      sck_oe_n_r <= ~(en_r && !ext_src);
      so_oe_n_r <= ~en_r;
    end
  end

  tws_shift_engine u_engine (
    .i_lclk(lclk),
    .i_rst(i_rst),
    .i_cfg(cfg),
    .i_tx_data(tx_r),
    .i_frame_id(frame_id_r),
    .i_si(i_si),
    .o_so_bit(so_bit),
    .o_done_tgl(done_tgl),
    .o_rx_data(link_rx)
  );

  assign o_cpu_rdata = rdata_r;
  assign o_sck = int_sck_r;
  assign o_sck_oe_n = sck_oe_n_r;
  assign o_so = dir_r & so_bit;
  assign o_so_oe_n = so_oe_n_r;
  assign o_busy = busy;
  assign o_xfer_done = done_pulse_r;

  // ************************************************************
  // checks
  // ************************************************************
  logic [7:0] gap_r;
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      gap_r <= 8'h00;
    end else if (!busy || $changed(int_sck_r)) begin
      gap_r <= 8'h01;
    end else begin
      gap_r <= gap_r + 8'h01;
    end
  end

  property p_clksel_rst;
    @(posedge i_sys_clk) $fell(i_rst) |-> clksel_r == 8'h10;
  endproperty
  a_clksel_rst: assert property (p_clksel_rst)
    else $error("clock select not 10H after reset");

  property p_type_rst;
    @(posedge i_sys_clk) $fell(i_rst) |-> phase_type == tws_pkg::PHASE_TYPE_RST;
  endproperty
  a_type_rst: assert property (p_type_rst)
    else $error("phase type not 3 after reset");

  property p_mode_rst;
    @(posedge i_sys_clk) $fell(i_rst) |-> mode_rd == 8'h00;
  endproperty
  a_mode_rst: assert property (p_mode_rst)
    else $error("mode register not 00H after reset");

  property p_dis_busy;
    @(posedge i_sys_clk) disable iff (i_rst) !en_r |-> !o_busy;
  endproperty
  a_dis_busy: assert property (p_dis_busy)
    else $error("busy while disabled");

  property p_tx_start;
    @(posedge i_sys_clk) disable iff (i_rst)
      wr_tx && dir_r && en_r && en_nxt && !busy
      |=> o_busy && $countones(frame_id_r ^ $past(frame_id_r)) == 1;
  endproperty
  a_tx_start: assert property (p_tx_start)
    else $error("buffer write did not start a transfer");

  property p_rx_start;
    @(posedge i_sys_clk) disable iff (i_rst)
      rd_shift && !dir_r && en_r && !wr_mode && !busy |=> o_busy;
  endproperty
  a_rx_start: assert property (p_rx_start)
    else $error("shift register read did not start a transfer");

  property p_done;
    @(posedge i_sys_clk) disable iff (i_rst)
      busy && done_evt && en_nxt |=> !o_busy && o_xfer_done ##1 !o_xfer_done;
  endproperty
  a_done: assert property (p_done)
    else $error("completion did not end the transfer");

  property p_so_low;
    @(posedge i_sys_clk) disable iff (i_rst) !dir_r |-> !o_so;
  endproperty
  a_so_low: assert property (p_so_low)
    else $error("data output not low in receive-only mode");

  property p_sck_idle;
    @(posedge i_sys_clk) disable iff (i_rst)
      !busy ##1 !busy && $stable(ckp) |-> o_sck == ~ckp;
  endproperty
  a_sck_idle: assert property (p_sck_idle)
    else $error("internal clock not at idle level");

  property p_half;
    @(posedge i_sys_clk) disable iff (i_rst)
      busy && $past(busy) && $changed(int_sck_r) && $stable(src)
      |-> gap_r == 8'(9'h002 << src) || edge_cnt_r == 5'h01;
  endproperty
  a_half: assert property (p_half)
    else $error("internal clock half period wrong");

  property p_sck_oe;
    @(posedge i_sys_clk) disable iff (i_rst)
      en_r && ext_src ##1 $stable(en_r) && $stable(src) |-> o_sck_oe_n;
  endproperty
  a_sck_oe: assert property (p_sck_oe)
    else $error("clock pin driven with external source");

endmodule

// ---- tb/tws_peer_model.sv ----
// Purpose: far-side peripheral on the three-wire serial pins
// Assumes: the bench sets sample edge polarity and bit order per frame
// Notes: after its eighth sample the peer releases its data line; with
//        no pull on it, the line shows the inverse of the last bit
`timescale 1ns/100ps
module tws_peer_model (
  // pins
  input wire logic i_sck,
  input wire logic i_so,
  output logic o_si,
  // frame setup
  input wire logic i_arm,
  input wire logic i_smp_rise,
  input wire logic i_lsb,
  input wire logic [7:0] i_tx,
  // result
  output logic [7:0] o_rx
);
  logic [3:0] n_smp;
  logic active;

  function automatic logic pick(input logic [7:0] d, input logic lsb,
                                input logic [3:0] k);
    return lsb ? d[k[2:0]] : d[3'h7 - k[2:0]];
  endfunction

  initial begin
    o_si = 1'b0;
    o_rx = 8'h00;
    n_smp = 4'h0;
    active = 1'b0;
  end

  // first bit is on the line before any edge, for the leading-sample phase
  always @(posedge i_arm) begin
    n_smp = 4'h0;
    active = 1'b1;
    o_si = pick(i_tx, i_lsb, 4'h0);
  end

  always @(i_sck) begin
    if (active && i_sck === i_smp_rise) begin
      o_rx = i_lsb ? {i_so, o_rx[7:1]} : {o_rx[6:0], i_so};
      n_smp = n_smp + 4'h1;
      if (n_smp == 4'h8) begin
        active = 1'b0;
        // let go after this edge, so the device still takes the last bit
        o_si <= ~o_si;
      end
    end else if (active) begin
      o_si = pick(i_tx, i_lsb, n_smp);
    end
  end
endmodule

// ---- tb/test_tws_port.sv ----
// Purpose: self-checking bench of the three-wire serial port
// Assumes: peer model answers on the far side of the pins
// Notes: CPU-side inputs change on the falling edge of the system clock
`timescale 1ns/100ps
module test_tws_port;
  logic clk, rst, wr, rd, ext_drv, arm, smp_rise, p_lsb;
  logic sck, sck_oe_n, si, so, so_oe_n, busy, done, sck_q;
  logic [15:0] addr;
  logic [7:0] wdata, rdata, p_tx, p_rx;
  int miscompares, checks, cyc, tog, t1, t2, ndone;
  // the clock pin carries whichever party drives it
  wire sck_pin = sck_oe_n ? ext_drv : sck;

  // ************************************************************
  // design and peer
  // ************************************************************
  tws_port i_dut (
    .i_sys_clk(clk), .i_rst(rst), .i_cpu_addr(addr), .i_cpu_wr(wr),
    .i_cpu_rd(rd), .i_cpu_wdata(wdata), .o_cpu_rdata(rdata),
    .i_ext_sck(sck_pin), .o_sck(sck), .o_sck_oe_n(sck_oe_n), .i_si(si),
    .o_so(so), .o_so_oe_n(so_oe_n), .o_busy(busy), .o_xfer_done(done)
  );
  tws_peer_model i_peer (
    .i_sck(sck_pin), .i_so(so), .o_si(si), .i_arm(arm),
    .i_smp_rise(smp_rise), .i_lsb(p_lsb), .i_tx(p_tx), .o_rx(p_rx)
  );

  // ************************************************************
  // clock, timeout and monitors
  // ************************************************************
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      miscompares++;
      close_out();
    end
  end

  always @(negedge clk) begin
    if (sck !== sck_q) begin
      if (tog == 0) t1 = cyc;
      if (tog == 1) t2 = cyc;
      tog++;
    end
    sck_q = sck;
    if (done === 1'b1) ndone++;
  end

  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic close_out();
    if (miscompares == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %0t mismatch seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cpu_wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask

  task automatic cpu_rd(input logic [15:0] a, output logic [7:0] d);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    @(negedge clk);
    d = rdata;
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic regs();
    logic [7:0] d;
    cpu_rd(tws_pkg::ADDR_MODE, d);
    check(d, 8'h00);
    cpu_rd(tws_pkg::ADDR_CLKSEL, d);
    check(d, 8'h10);
    check(8'({1'b0, d[4:3]} + 3'h1), 8'h03);
    check(8'({sck_oe_n, so_oe_n, sck, busy}), 8'h0c);
    cpu_wr(tws_pkg::ADDR_CLKSEL, 8'hff);
    cpu_rd(tws_pkg::ADDR_CLKSEL, d);
    check(d, 8'h1f);
    cpu_wr(tws_pkg::ADDR_MODE, 8'h0f);
    cpu_rd(tws_pkg::ADDR_MODE, d);
    check(d, 8'h00);
    cpu_rd(16'hffb4, d);
    check(d, 8'h00);
  endtask

  // one whole frame; pb is what the peer sends back
  task automatic frame(input logic [2:0] src, input logic ckp, dap, lsb,
                       input logic dir, input logic [7:0] tx, pb);
    logic [7:0] d;
    int n;
    arm = 1'b0;
    cpu_wr(tws_pkg::ADDR_MODE, 8'h00);
    ext_drv = !ckp;
    cpu_wr(tws_pkg::ADDR_CLKSEL, {3'h0, ckp, dap, src});
    cpu_wr(tws_pkg::ADDR_MODE, {1'b1, dir, 1'b0, lsb, 4'h0});
    @(negedge clk);
    check(8'(so_oe_n), 8'h00);
    check(8'(sck_oe_n), 8'(src == tws_pkg::SRC_EXTERNAL));
    p_tx = pb;
    p_lsb = lsb;
    smp_rise = !(ckp ^ dap);
    arm = 1'b1;
    tog = 0;
    ndone = 0;
    if (!dir) begin
      cpu_wr(tws_pkg::ADDR_TXBUF, tx);
      @(negedge clk);
      check(8'(busy), 8'h00);
    end
    if (dir)
      cpu_wr(tws_pkg::ADDR_TXBUF, tx);
    else
      cpu_rd(tws_pkg::ADDR_SHIFT, d);
    @(negedge clk);
    check(8'(busy), 8'h01);
    if (dir && dap)
      check(8'(lsb ? tx[0] : tx[7]), 8'(so));
    if (src == tws_pkg::SRC_EXTERNAL) begin
      #7;
      repeat (16) #15 ext_drv = ~ext_drv;
    end
    n = 0;
    while (ndone == 0 && n < 2500) begin
      @(negedge clk);
      n++;
    end
    check(8'(busy), 8'h00);
    repeat (4) @(negedge clk);
    check(8'(ndone), 8'h01);
    check(p_rx, dir ? tx : 8'h00);
    check(8'(so), 8'(dir & (lsb ? tx[7] : tx[0])));
    if (src != tws_pkg::SRC_EXTERNAL) begin
      check(8'(tog), 8'h10);
      check(8'(t2 - t1), 8'(1 << (src + 1)));
      check(8'(sck), 8'(!ckp));
    end
    cpu_wr(tws_pkg::ADDR_MODE, 8'h00);
    @(negedge clk);
    check(8'({so_oe_n, sck_oe_n}), 8'h03);
    cpu_rd(tws_pkg::ADDR_SHIFT, d);
    check(d, pb);
  endtask

  // disable in mid-frame: busy must drop at once, no late completion
  task automatic abort();
    cpu_wr(tws_pkg::ADDR_CLKSEL, 8'h16);
    cpu_wr(tws_pkg::ADDR_MODE, 8'hc0);
    cpu_wr(tws_pkg::ADDR_TXBUF, 8'h81);
    repeat (200) @(negedge clk);
    ndone = 0;
    cpu_wr(tws_pkg::ADDR_MODE, 8'h00);
    check(8'(busy), 8'h00);
    @(negedge clk);
    check(8'({so_oe_n, sck_oe_n}), 8'h03);
    repeat (40) @(negedge clk);
    check(8'(ndone), 8'h00);
  endtask

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    rst = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 16'h0000;
    wdata = 8'h00;
    ext_drv = 1'b0;
    arm = 1'b0;
    smp_rise = 1'b0;
    p_lsb = 1'b0;
    p_tx = 8'h00;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    regs();
    for (int t = 0; t < 8; t++)
      frame(3'h0, t[2], t[1], t[0], 1'b1, 8'h4b + 8'(t * 37),
            8'hc3 ^ 8'(t));
    for (int s = 1; s < 7; s++)
      frame(3'(s), 1'b1, 1'b0, 1'b0, 1'b1, 8'h96, 8'h5a);
    frame(3'h0, 1'b1, 1'b0, 1'b0, 1'b0, 8'hff, 8'h3c);
    frame(3'h3, 1'b0, 1'b1, 1'b1, 1'b0, 8'hff, 8'h71);
    frame(tws_pkg::SRC_EXTERNAL, 1'b1, 1'b0, 1'b0, 1'b1, 8'ha5, 8'h0f);
    frame(tws_pkg::SRC_EXTERNAL, 1'b0, 1'b1, 1'b1, 1'b1, 8'h2d, 8'he4);
    abort();
    close_out();
  end
endmodule
